//--- design/seba_defs.vh
// Constants for the serial EEPROM two-wire slave front end
`ifndef SEBA_DEFS_VH
`define SEBA_DEFS_VH
`define SEBA_FIXED_TOP_BIT 7
`define SEBA_SEL_HIGH_BIT 6
`define SEBA_SEL_MID_BIT 5
`define SEBA_SEL_LOW_BIT 4
`define SEBA_UPPER_ADDR_MSB 3
`define SEBA_UPPER_ADDR_LSB 1
`define SEBA_DIR_BIT 0
`define SEBA_ADDR_W 11
`define SEBA_BITS_PER_BYTE 4'h8
`define SEBA_ADDR_RESET 11'h000
`endif

//--- design/seba_cond_det.v
// Bus-line edge and START/STOP condition detector
module seba_cond_det (
   input wire clock_i, // System clock
   input wire reset_i, // Synchronous reset, active high
   input wire scl_i, // Serial clock level
   input wire sda_i, // Serial data level, wired-AND resolved
   output wire scl_rise_o, // Pulse on serial clock rising edge
   output wire scl_fall_o, // Pulse on serial clock falling edge
   output wire start_o, // Pulse on START condition
   output wire stop_o // Pulse on STOP condition
);
   reg scl_ff;
   reg sda_ff;
   always @(posedge clock_i) begin
      if (reset_i) begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
      end else begin
         scl_ff <= scl_i;
         sda_ff <= sda_i;
      end
   end
   assign scl_rise_o = scl_i & ~scl_ff;
   assign scl_fall_o = ~scl_i & scl_ff;
   // Data edge while clock stays high
   assign start_o = scl_i & scl_ff & sda_ff & ~sda_i; // [R4]
   assign stop_o = scl_i & scl_ff & ~sda_ff & sda_i; // [R5]
endmodule

//--- design/seba_cmd_dec.v
// Command byte decoder: device match, direction and upper address
`include "seba_defs.vh"

module seba_cmd_dec (
   input wire [7:0] cmd_i, // Received command byte
   input wire select_pin_low_i, // Strapped low select pin
   input wire select_pin_mid_i, // Strapped middle select pin
   input wire select_pin_high_i, // Strapped high select pin
   output wire match_o, // Command addresses this device
   output wire read_o, // Direction, high for read
   output wire [2:0] upper_addr_o // Address bits 10..8
);
   wire select_bit_high;
   wire select_bit_mid;
   wire select_bit_low;
   assign select_bit_high = cmd_i[`SEBA_SEL_HIGH_BIT];
   assign select_bit_mid = cmd_i[`SEBA_SEL_MID_BIT];
   assign select_bit_low = cmd_i[`SEBA_SEL_LOW_BIT];
   assign match_o = cmd_i[`SEBA_FIXED_TOP_BIT] // [R15] [R22]
      & (select_bit_high == select_pin_high_i) // [R16]
      & (select_bit_mid == ~select_pin_mid_i) // [R16]
      & (select_bit_low == select_pin_low_i);
   assign read_o = cmd_i[`SEBA_DIR_BIT]; // [R17]
   assign upper_addr_o = cmd_i[`SEBA_UPPER_ADDR_MSB:`SEBA_UPPER_ADDR_LSB];
endmodule

//--- design/seba_slave.v
// Two-wire slave front end of a 2048-byte serial EEPROM
`include "seba_defs.vh"

// What this block does
// R1: Master starts transfers and clocks the bus; this block is slave only.
// R2: Data line driven open-drain only; low wins.
// R3: Return to idle after STOP or end of programming.
// R4: START is falling data while clock high; detected.
// R5: STOP is rising data while clock high; recognised anywhere.
// R6: STOP ending a write transfer starts programming.
// R7: STOP after a sent data byte enters standby, no programming.
// R8: Receiver pulls data low for whole ninth clock as acknowledge.
// R9: Transmitter releases data line after eight bits.
// R10: Addressed receiving device acknowledges each accepted byte.
// R11: Master acknowledges read bytes; ends with no-ack then STOP.
// R12: Data changes only while clock low except START/STOP.
// R13: Nine clocks per byte, eight bits MSB first then acknowledge.
// R14: Master sends a command byte right after every START.
// R15: Command bit 7 must be 1; bits 6..4 compared with select pins.
// R16: Middle select bit matches inverted middle pin; others direct.
// R17: Command bit 0: 0 write, 1 read.
// R18: Write command bits 3..1 load address bits 10..8.
// R19: Read command bits 3..1 ignored; address kept.
// R20: Byte after write command loads address bits 7..0.
// R21: After read command send data while master acknowledges.
// R22: Command forms identified by top bit 1 and direction bit.
// R23: Sample on rising clock edge, drive on falling edge.
// R24: Address counter steps after each acked write byte and each read byte.
// R25: No acknowledge to commands while programming runs.
// R26: Mismatch leaves data released and ignores traffic until START.
module seba_slave #(
   parameter ADDR_W = `SEBA_ADDR_W
) (
   input wire clock_i, // System clock, 250 MHz
   input wire reset_i, // Synchronous reset, active high
   input wire scl_i, // Serial clock from master
   input wire sda_i, // Serial data line level
   output wire sda_o, // Serial data drive value, always low
   output wire sda_oe_o, // High while pulling data line low
   input wire select_pin_low_i, // Strapped low select pin
   input wire select_pin_mid_i, // Strapped middle select pin
   input wire select_pin_high_i, // Strapped high select pin
   input wire prog_busy_i, // Programming cycle running
   input wire [7:0] rd_data_i, // Memory byte at current address
   output reg [ADDR_W-1:0] addr_ff, // Address counter
   output reg [7:0] wr_data_ff, // Last received data byte
   output reg wr_strobe_ff, // Pulse: data byte acknowledged
   output reg prog_start_ff, // Pulse: start programming cycle
   output reg busy_ff // Transfer in progress
);
   localparam ST_IDLE = 3'h0;
   localparam ST_CMD = 3'h1;
   localparam ST_ADDR = 3'h2;
   localparam ST_WDATA = 3'h3;
   localparam ST_RDATA = 3'h4;
   localparam ST_MACK = 3'h5;
   localparam ST_IGNORE = 3'h6;

   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   wire cmd_match;
   wire cmd_read;
   wire [2:0] cmd_upper;

   reg [2:0] state_ff;
   reg [3:0] bit_cnt_ff;
   reg [7:0] shift_ff;
   reg ack_phase_ff;
   reg ack_drive_ff;
   reg data_drive_ff;
   reg wrote_ff;
   reg [7:0] tx_ff;

   seba_cond_det u_cond (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_rise_o(scl_rise),
      .scl_fall_o(scl_fall),
      .start_o(start_det),
      .stop_o(stop_det)
   );

   seba_cmd_dec u_dec (
      .cmd_i({shift_ff[6:0], sda_i}),
      .select_pin_low_i(select_pin_low_i),
      .select_pin_mid_i(select_pin_mid_i),
      .select_pin_high_i(select_pin_high_i),
      .match_o(cmd_match),
      .read_o(cmd_read),
      .upper_addr_o(cmd_upper)
   );

   // Only ever pull low; release otherwise
   assign sda_o = 1'b0; // [R2]
   assign sda_oe_o = ack_drive_ff | data_drive_ff; // [R2]

   always @(posedge clock_i) begin
      wr_strobe_ff <= 1'b0;
      prog_start_ff <= 1'b0;
      if (reset_i) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         ack_phase_ff <= 1'b0;
         ack_drive_ff <= 1'b0;
         data_drive_ff <= 1'b0;
         wrote_ff <= 1'b0;
         tx_ff <= 8'h00;
         addr_ff <= `SEBA_ADDR_RESET;
         wr_data_ff <= 8'h00;
         busy_ff <= 1'b0;
      end else if (stop_det) begin
         // A STOP ends everything; program only if data was written
         if (state_ff == ST_WDATA && wrote_ff) begin
            prog_start_ff <= 1'b1; // [R6]
         end
         state_ff <= ST_IDLE; // [R3] [R5] [R7]
         ack_drive_ff <= 1'b0;
         data_drive_ff <= 1'b0;
         wrote_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else if (start_det) begin
         // Repeated START also lands here and abandons a pending write
         state_ff <= ST_CMD; // [R4] [R14]
         bit_cnt_ff <= 4'h0;
         ack_phase_ff <= 1'b0;
         ack_drive_ff <= 1'b0;
         data_drive_ff <= 1'b0;
         wrote_ff <= 1'b0;
         busy_ff <= 1'b1;
      end else begin
         case (state_ff)
            ST_IDLE, ST_IGNORE: begin
               ack_drive_ff <= 1'b0; // [R26]
               data_drive_ff <= 1'b0;
               busy_ff <= (state_ff == ST_IGNORE);
            end
            ST_CMD, ST_ADDR, ST_WDATA: begin
               if (!ack_phase_ff) begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_i}; // [R13] [R23]
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     if (bit_cnt_ff == `SEBA_BITS_PER_BYTE - 4'h1) begin
                        bit_cnt_ff <= 4'h0;
                        ack_phase_ff <= 1'b1;
                        if (state_ff == ST_CMD) begin
                           if (!cmd_match || prog_busy_i) begin
                              state_ff <= ST_IGNORE; // [R25] [R26]
                              ack_phase_ff <= 1'b0;
                           end else if (!cmd_read) begin
                              addr_ff[ADDR_W-1:ADDR_W-3] <= cmd_upper; // [R18]
                           end
                           // Read command keeps the address untouched [R19]
                        end else if (state_ff == ST_ADDR) begin
                           addr_ff[7:0] <= {shift_ff[6:0], sda_i}; // [R20]
                        end else begin
                           wr_data_ff <= {shift_ff[6:0], sda_i};
                        end
                     end
                  end
                  if (scl_fall && bit_cnt_ff == 4'h0 && ack_drive_ff) begin
                     ack_drive_ff <= 1'b0;
                  end
               end else begin
                  // Ack is held from the falling edge after bit 8 to the next fall
                  if (scl_fall && !ack_drive_ff) begin
                     ack_drive_ff <= 1'b1; // [R8] [R10] [R12]
                  end else if (scl_fall && ack_drive_ff) begin
                     ack_drive_ff <= 1'b0;
                     ack_phase_ff <= 1'b0;
                     if (state_ff == ST_CMD) begin
                        if (shift_ff[`SEBA_DIR_BIT]) begin
                           state_ff <= ST_RDATA; // [R21]
                           tx_ff <= rd_data_i;
                           data_drive_ff <= ~rd_data_i[7]; // [R23]
                        end else begin
                           state_ff <= ST_ADDR;
                        end
                     end else if (state_ff == ST_ADDR) begin
                        state_ff <= ST_WDATA;
                     end else begin
                        wr_strobe_ff <= 1'b1;
                        wrote_ff <= 1'b1;
                        // Address steps within a page only is left to the writer
                        addr_ff <= addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1}; // [R24]
                     end
                  end
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  if (bit_cnt_ff == `SEBA_BITS_PER_BYTE - 4'h1) begin
                     bit_cnt_ff <= 4'h0;
                     data_drive_ff <= 1'b0; // [R9]
                     state_ff <= ST_MACK;
                     // Counter steps during each byte read, rolling over at the top
                     addr_ff <= addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1}; // [R24]
                  end else begin
                     tx_ff <= {tx_ff[6:0], 1'b0};
                     data_drive_ff <= ~tx_ff[6]; // [R13] [R23]
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  // Master no-ack: release and wait for STOP
                  wrote_ff <= sda_i; // [R11]
               end
               if (scl_fall) begin
                  if (!wrote_ff) begin
                     state_ff <= ST_RDATA; // [R21]
                     tx_ff <= rd_data_i;
                     data_drive_ff <= ~rd_data_i[7];
                  end else begin
                     state_ff <= ST_IGNORE; // [R7]
                  end
                  wrote_ff <= 1'b0;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end
   // [R1] The block never drives the clock; all timing follows scl_i
endmodule

//--- verif/seba_chk.sv
// Concurrent checks on the two-wire slave ports
module seba_chk #(
   parameter ADDR_W = 11
) (
   input wire clock_i, // Clock
   input wire reset_i, // Reset
   input wire scl_i, // Bus clock
   input wire sda_i, // Data line
   input wire sda_o, // Drive value
   input wire sda_oe_o, // Pull enable
   input wire select_pin_low_i, // Strap
   input wire select_pin_mid_i, // Strap
   input wire select_pin_high_i, // Strap
   input wire prog_busy_i, // Programming
   input wire [7:0] rd_data_i, // Read byte
   input wire [ADDR_W-1:0] addr_ff, // Address
   input wire [7:0] wr_data_ff, // Write byte
   input wire wr_strobe_ff, // Byte pulse
   input wire prog_start_ff, // Program pulse
   input wire busy_ff // In transfer
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   AST_PULL_LOW: assert property (sda_o == 1'b0) else $error("data drive not low");
   AST_HOLD_HIGH: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
      else $error("data moved while clock high");
   AST_MOVE_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data drive changed outside low phase");
   AST_START_BUSY: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> ##[0:3] busy_ff)
      else $error("start not seen");
   AST_STOP_IDLE: assert property (scl_i && $past(scl_i) && $rose(sda_i) |-> ##[0:3] !busy_ff)
      else $error("stop not seen");
   AST_PROG_AT_STOP: assert property (prog_start_ff |-> scl_i && sda_i)
      else $error("programming started off a stop");
   AST_PROG_PULSE: assert property (prog_start_ff |=> !prog_start_ff)
      else $error("programming start too long");
   AST_STROBE_STEP: assert property ($rose(wr_strobe_ff) |-> addr_ff == $past(addr_ff) + 1'b1)
      else $error("address did not step");
   AST_IDLE_RELEASED: assert property (!busy_ff && !$past(busy_ff) |-> !sda_oe_o)
      else $error("data pulled while idle");
endmodule
bind seba_slave seba_chk #(.ADDR_W(ADDR_W)) i_seba_chk (
   .clock_i(clock_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .select_pin_low_i(select_pin_low_i),
   .select_pin_mid_i(select_pin_mid_i), .select_pin_high_i(select_pin_high_i),
   .prog_busy_i(prog_busy_i), .rd_data_i(rd_data_i), .addr_ff(addr_ff),
   .wr_data_ff(wr_data_ff), .wr_strobe_ff(wr_strobe_ff), .prog_start_ff(prog_start_ff),
   .busy_ff(busy_ff)
);

//--- verif/seba_master.sv
// Behavioural two-wire bus master
module seba_master (
   input wire clock_i, // Pacing clock
   input wire sda_i, // Resolved data line
   output logic scl_o, // Bus clock
   output logic sda_low_o // High while pulling data low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic pace(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   // One bit: data set in low phase, line sampled mid high phase
   task automatic bit_x(input logic b, output logic r);
      scl_o = 1'b0;
      pace(2);
      sda_low_o = !b;
      pace(2);
      scl_o = 1'b1;
      pace(2);
      r = sda_i;
      pace(2);
   endtask
   // High level first gives a start, low first gives a stop
   task automatic cond(input logic to_high);
      scl_o = 1'b0;
      pace(2);
      sda_low_o = to_high;
      pace(2);
      scl_o = 1'b1;
      pace(4);
      sda_low_o = !to_high;
      pace(4);
   endtask
   task automatic byte_x(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
         output logic s_ack);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(!m_ack, s_ack);
      s_ack = !s_ack;
   endtask
endmodule

//--- verif/testbench.sv
// Self-checking bench for the two-wire slave
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic [2:0] pins = 3'b000; // High, mid, low strap
   // Programming model: busy for a fixed stretch after each start pulse
   logic [8:0] prog_cnt = 9'h000;
   wire prog_busy = (prog_cnt != 9'h000);
   int strobe_cnt = 0;
   logic scl, sda_low, ack;
   logic prog_seen = 1'b0;
   logic [7:0] q;
   wire sda_o, sda_oe, wr_strobe, prog_start, busy;
   wire [10:0] addr;
   wire [7:0] wr_data;
   wire [7:0] rd_data = addr[7:0] ^ 8'h5a;
   wire sda_line = (sda_oe ? sda_o : 1'b1) & !sda_low;
   int miscompares = 0;
   int total_checks = 0;
   // Rows of strap, command byte and expected acknowledge
   logic [11:0] rows [10] = '{12'h141, 12'h040, 12'h1c0, 12'h160, 12'h100,
      12'h143, 12'hfa3, 12'hbe1, 12'hba0, 12'h503};
   seba_slave #(.ADDR_W(11)) i_seba_slave (.clock_i(clock_i), .reset_i(reset_i),
      .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .select_pin_low_i(pins[0]), .select_pin_mid_i(pins[1]), .select_pin_high_i(pins[2]),
      .prog_busy_i(prog_busy), .rd_data_i(rd_data), .addr_ff(addr), .wr_data_ff(wr_data),
      .wr_strobe_ff(wr_strobe), .prog_start_ff(prog_start), .busy_ff(busy));
   seba_master i_seba_master (.clock_i(clock_i), .sda_i(sda_line), .scl_o(scl),
      .sda_low_o(sda_low));
   always #2 clock_i = !clock_i;
   always @(posedge clock_i) if (prog_start) prog_seen <= 1'b1;
   always @(posedge clock_i) begin
      if (prog_start) prog_cnt <= 9'h12c;
      else if (prog_cnt != 9'h000) prog_cnt <= prog_cnt - 9'h001;
   end
   always @(posedge clock_i) if (wr_strobe) strobe_cnt++;
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c, input logic exp_ack);
      i_seba_master.cond(1'b0);
      i_seba_master.byte_x(c, 1'b0, q, ack);
      chk(11'(ack), 11'(exp_ack));
   endtask
   initial begin
      repeat (20000) @(posedge clock_i);
      miscompares++;
      conclude;
   end
   initial begin
      repeat (16) @(posedge clock_i);
      @(negedge clock_i);
      reset_i = 1'b0;
      chk({9'h0, sda_oe, busy}, 11'h000);
      chk(addr, 11'h000);
      foreach (rows[i]) begin
         pins = rows[i][11:9];
         cmd(rows[i][8:1], rows[i][0]);
         if (rows[i][0] && rows[i][1]) i_seba_master.byte_x(8'hff, 1'b0, q, ack);
         i_seba_master.cond(1'b1);
      end
      pins = 3'b000;
      cmd(8'ha6, 1'b1);
      i_seba_master.byte_x(8'h3c, 1'b0, q, ack);
      i_seba_master.byte_x(8'h96, 1'b0, q, ack);
      chk(11'(ack), 11'h1);
      i_seba_master.cond(1'b1);
      chk(addr, 11'h33d);
      chk(11'(wr_data), 11'h096);
      chk({9'h0, prog_seen, busy}, 11'h002);
      chk(11'(strobe_cnt), 11'h001);
      // Polling while the programming cycle still runs gets no acknowledge
      cmd(8'ha0, 1'b0);
      i_seba_master.cond(1'b1);
      for (int n = 0; n < 1000 && prog_busy; n++) @(negedge clock_i);
      chk(11'(prog_busy), 11'h0);
      prog_seen = 1'b0;
      cmd(8'haf, 1'b1);
      i_seba_master.byte_x(8'hff, 1'b1, q, ack);
      chk(11'(q), 11'(8'h3d ^ 8'h5a));
      i_seba_master.byte_x(8'hff, 1'b0, q, ack);
      chk(11'(q), 11'(8'h3e ^ 8'h5a));
      i_seba_master.cond(1'b1);
      chk(addr, 11'h33f);
      chk(11'(prog_seen), 11'h0);
      // Repeated start after the address abandons the write
      cmd(8'hae, 1'b1);
      i_seba_master.byte_x(8'hff, 1'b0, q, ack);
      cmd(8'ha1, 1'b1);
      i_seba_master.byte_x(8'hff, 1'b0, q, ack);
      i_seba_master.cond(1'b1);
      chk(11'(q), 11'(8'hff ^ 8'h5a));
      chk(addr, 11'h000);
      chk(11'(prog_seen), 11'h0);
      conclude;
   end
endmodule
